// [logic/splc_pkg.sv]
// constants and types for the stack pointer limit checker
package splc_pkg;
   // ----------------------------------------------------------------
   // bus
   // ----------------------------------------------------------------
   localparam int unsigned SPLC_AW = 8;
   localparam logic [7:0] SPLC_OFF_LIMIT = 8'h00;
   localparam logic [7:0] SPLC_OFF_SP = 8'h04;
   localparam logic [7:0] SPLC_OFF_STATUS = 8'h08;
   localparam logic [7:0] SPLC_OFF_CLEAR = 8'h0c;
   localparam logic [7:0] SPLC_OFF_ENABLE = 8'h10;
   localparam logic [1:0] SPLC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SPLC_RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // stack
   // ----------------------------------------------------------------
   localparam logic [15:0] SPLC_SP_RESET = 16'h0800;
   localparam logic [15:0] SPLC_UNDERFLOW_BASE = 16'h0800;
   localparam logic [15:0] SPLC_WORD_BYTES = 16'h0002;
   localparam logic [7:0] SPLC_ZERO_BYTE = 8'h00;
   localparam int unsigned SPLC_PC_W = 23;
   // ----------------------------------------------------------------
   // events
   // ----------------------------------------------------------------
   localparam int unsigned SPLC_NEV = 2;
   localparam int unsigned SPLC_EV_OVF = 0;
   localparam int unsigned SPLC_EV_UDF = 1;

   typedef enum logic [2:0] {
      SPLC_OP_PUSH,
      SPLC_OP_POP,
      SPLC_OP_CALL,
      SPLC_OP_EXC,
      SPLC_OP_WRSP,
      SPLC_OP_EACHK
   } splc_op_t;

   typedef enum logic {
      SPLC_ST_IDLE,
      SPLC_ST_PC_HI
   } splc_state_t;
endpackage

// [logic/splc_axil.sv]
// axi4-lite slave front end for the stack limit registers
`timescale 1ns/1ns
module splc_axil
   import splc_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [SPLC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SPLC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [SPLC_AW-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic rd_en,
   output logic [SPLC_AW-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic wr_go, rd_go;

   // waits for address and data together, one write in flight
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
   assign rd_go = s_axi_arvalid & ~arready_ff & ~rvalid_ff;
   assign wr_en = s_axi_awvalid & s_axi_wvalid & awready_ff;
   assign rd_en = s_axi_arvalid & arready_ff;
   assign wr_addr = s_axi_awaddr;
   assign wr_data = s_axi_wdata;
   assign wr_strb = s_axi_wstrb;
   assign rd_addr = s_axi_araddr;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         awready_ff <= 1'b0;
         arready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         bresp_ff <= SPLC_RESP_OKAY;
         rresp_ff <= SPLC_RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else begin
         awready_ff <= wr_go;
         arready_ff <= rd_go;
         if (wr_en) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? SPLC_RESP_OKAY : SPLC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (rd_en) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_ok ? SPLC_RESP_OKAY : SPLC_RESP_SLVERR;
            rdata_ff <= rd_ok ? rd_data : 32'h0000_0000;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = awready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
endmodule

// [logic/splc_top.sv]
// stack pointer, push/pop addressing and stack limit trap unit
`timescale 1ns/1ns
// Overview of operation
// - stack pointer register also a plain working register
// - pointer holds next free word, grows upward
// - pop predecrements, push writes then postincrements
// - call push clears stacked pc upper byte
// - exception push stacks status low byte high
// - limit register has no reset value
// - limit bit zero reads zero once the low byte has been written
// - every pointer-based address compared against limit
// - push at limit allowed, next one traps
// - address below 0800h raises underflow trap
module splc_top
   import splc_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [SPLC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SPLC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic op_valid,
   input wire splc_op_t op_kind,
   input wire logic [15:0] op_data,
   input wire logic [SPLC_PC_W-1:0] pc_in,
   input wire logic [7:0] status_low_byte,
   output logic op_ready,
   output logic [15:0] stack_pointer_reg,
   output logic mem_we,
   output logic mem_re,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic stack_trap,
   output logic irq
);
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic wr_en, rd_en, wr_ok, rd_ok;
   logic [SPLC_AW-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;

   splc_axil u_axil (
      .core_clk(core_clk),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   logic [15:0] limit_ff;
   logic [15:0] sp_ff, nxt_sp;
   logic [SPLC_NEV-1:0] status_ff, nxt_status, enable_ff;
   logic irq_ff;

   wire wr_limit = wr_en & (wr_addr == SPLC_OFF_LIMIT);
   wire wr_clear = wr_en & (wr_addr == SPLC_OFF_CLEAR) & wr_strb[0];
   wire wr_enable = wr_en & (wr_addr == SPLC_OFF_ENABLE) & wr_strb[0];
   assign wr_ok = (wr_addr == SPLC_OFF_LIMIT) |
                  (wr_addr == SPLC_OFF_CLEAR) |
                  (wr_addr == SPLC_OFF_ENABLE);
   assign rd_ok = (rd_addr == SPLC_OFF_LIMIT) |
                  (rd_addr == SPLC_OFF_SP) |
                  (rd_addr == SPLC_OFF_STATUS) |
                  (rd_addr == SPLC_OFF_CLEAR) |
                  (rd_addr == SPLC_OFF_ENABLE);
   // clear register reads as zero
   wire [15:0] rd_word =
      (rd_addr == SPLC_OFF_LIMIT) ? limit_ff :
      (rd_addr == SPLC_OFF_SP) ? sp_ff :
      (rd_addr == SPLC_OFF_STATUS) ? {14'h0000, status_ff} :
      (rd_addr == SPLC_OFF_ENABLE) ? {14'h0000, enable_ff} : 16'h0000;
   assign rd_data = {16'h0000, rd_word};

   // ----------------------------------------------------------------
   // limit register
   // ----------------------------------------------------------------
   // deliberately no reset: software must load it before relying on it
   always_ff @(posedge core_clk) begin
      if (wr_limit && wr_strb[0]) begin
         limit_ff[7:0] <= {wr_data[7:1], 1'b0};
      end
      if (wr_limit && wr_strb[1]) begin
         limit_ff[15:8] <= wr_data[15:8];
      end
   end

   // ----------------------------------------------------------------
   // operation decode and address checking
   // ----------------------------------------------------------------
   splc_state_t state_ff, nxt_state;
   logic [SPLC_PC_W-1:0] pc_ff;
   logic [7:0] hibyte_ff;
   logic op_ready_ff;

   wire acc = op_valid & op_ready_ff;
   wire in_hi = (state_ff == SPLC_ST_PC_HI);
   wire is_push = acc & ((op_kind == SPLC_OP_PUSH) |
                         (op_kind == SPLC_OP_CALL) |
                         (op_kind == SPLC_OP_EXC));
   wire is_pop = acc & (op_kind == SPLC_OP_POP);
   wire is_chk = acc & (op_kind == SPLC_OP_EACHK);
   wire is_wrsp = acc & (op_kind == SPLC_OP_WRSP);
   wire is_pc = acc & ((op_kind == SPLC_OP_CALL) |
                       (op_kind == SPLC_OP_EXC));
   wire [15:0] sp_dec = sp_ff - SPLC_WORD_BYTES;
   wire [15:0] sp_inc = sp_ff + SPLC_WORD_BYTES;
   // effective address produced through the stack pointer, or taken from op_data for an address check
   wire [15:0] ea = is_pop ? sp_dec : (is_chk ? op_data : sp_ff);
   wire ea_live = is_push | is_pop | is_chk | in_hi;
   // push at sp == limit passes, only beyond it traps
   wire ovf = ea_live & (ea > limit_ff);
   wire udf = ea_live & (ea < SPLC_UNDERFLOW_BASE);
   wire trap = ovf | udf;
   wire do_write = ((is_push | in_hi) & ~trap);
   wire do_read = is_pop & ~trap;
   wire [15:0] hi_word = {hibyte_ff, 1'b0, pc_ff[SPLC_PC_W-1:16]};
   wire [15:0] wdata =
      in_hi ? hi_word :
      (is_pc ? pc_in[15:0] : op_data);

   always_comb begin
      nxt_sp = sp_ff;
      if (is_wrsp) begin
         nxt_sp = {op_data[15:1], 1'b0};
      end else if (do_write) begin
         nxt_sp = sp_inc;
      end else if (do_read) begin
         nxt_sp = sp_dec;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SPLC_ST_IDLE: begin
            if (is_pc && !trap) begin
               nxt_state = SPLC_ST_PC_HI;
            end
         end
         SPLC_ST_PC_HI: begin
            nxt_state = SPLC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= SPLC_ST_IDLE;
         sp_ff <= SPLC_SP_RESET;
         op_ready_ff <= 1'b1;
         pc_ff <= '0;
         hibyte_ff <= SPLC_ZERO_BYTE;
      end else begin
         state_ff <= nxt_state;
         sp_ff <= nxt_sp;
         op_ready_ff <= (nxt_state == SPLC_ST_IDLE);
         if (is_pc) begin
            pc_ff <= pc_in;
            // call stacks a clear byte, exception stacks the status byte
            hibyte_ff <= (op_kind == SPLC_OP_EXC) ?
                         status_low_byte : SPLC_ZERO_BYTE;
         end
      end
   end

   // ----------------------------------------------------------------
   // memory strobes and trap
   // ----------------------------------------------------------------
   logic mem_we_ff, mem_re_ff, trap_ff;
   logic [15:0] mem_addr_ff, mem_wdata_ff;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mem_we_ff <= 1'b0;
         mem_re_ff <= 1'b0;
         mem_addr_ff <= 16'h0000;
         mem_wdata_ff <= 16'h0000;
         trap_ff <= 1'b0;
      end else begin
         mem_we_ff <= do_write;
         mem_re_ff <= do_read;
         trap_ff <= trap;
         if (do_write || do_read) begin
            mem_addr_ff <= ea;
         end
         if (do_write) begin
            mem_wdata_ff <= wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   wire [SPLC_NEV-1:0] ev = {udf, ovf};

   // a new event in the clearing cycle survives the clear
   assign nxt_status = (status_ff & ~(wr_clear ?
                        wr_data[SPLC_NEV-1:0] : 2'h0)) | ev;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status_ff <= '0;
         enable_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         irq_ff <= |(status_ff & enable_ff);
         if (wr_enable) begin
            enable_ff <= wr_data[SPLC_NEV-1:0];
         end
      end
   end

   assign op_ready = op_ready_ff;
   assign stack_pointer_reg = sp_ff;
   assign mem_we = mem_we_ff;
   assign mem_re = mem_re_ff;
   assign mem_addr = mem_addr_ff;
   assign mem_wdata = mem_wdata_ff;
   assign stack_trap = trap_ff;
   assign irq = irq_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_call_hi;
      is_pc && !trap && op_kind == SPLC_OP_CALL ##1 in_hi;
   endsequence
   sequence s_exc_hi;
      is_pc && !trap && op_kind == SPLC_OP_EXC ##1 in_hi;
   endsequence

   property p_push_inc;
      @(posedge core_clk) disable iff (!resetn)
      is_push && !trap |=> sp_ff == $past(sp_ff) + SPLC_WORD_BYTES
                           && mem_addr_ff == $past(sp_ff) && mem_we_ff;
   endproperty
   a_push_inc: assert property (p_push_inc)
      else $error("push did not write at sp then add two");

   property p_pop_dec;
      @(posedge core_clk) disable iff (!resetn)
      is_pop && !trap |=> mem_re_ff && sp_ff == mem_addr_ff
                          && sp_ff == $past(sp_ff) - SPLC_WORD_BYTES;
   endproperty
   a_pop_dec: assert property (p_pop_dec)
      else $error("pop did not predecrement by two");

   property p_at_limit;
      @(posedge core_clk) disable iff (!resetn)
      is_push && sp_ff == limit_ff && sp_ff >= SPLC_UNDERFLOW_BASE
         |=> !trap_ff && mem_we_ff;
   endproperty
   a_at_limit: assert property (p_at_limit)
      else $error("push at limit trapped");

   property p_over_limit;
      @(posedge core_clk) disable iff (!resetn)
      (is_push || is_chk) && ea > limit_ff |=> trap_ff && !mem_we_ff
                                               && status_ff[SPLC_EV_OVF];
   endproperty
   a_over_limit: assert property (p_over_limit)
      else $error("address beyond limit not trapped");

   property p_underflow;
      @(posedge core_clk) disable iff (!resetn)
      ea_live && ea < SPLC_UNDERFLOW_BASE |=> trap_ff
         && status_ff[SPLC_EV_UDF] && !mem_re_ff;
   endproperty
   a_underflow: assert property (p_underflow)
      else $error("underflow not trapped");

   property p_call_clear;
      @(posedge core_clk) disable iff (!resetn)
      s_call_hi |=> trap_ff
         || (mem_we_ff && mem_wdata_ff[15:8] == SPLC_ZERO_BYTE);
   endproperty
   a_call_clear: assert property (p_call_clear)
      else $error("call push upper byte not clear");

   property p_exc_srl;
      @(posedge core_clk) disable iff (!resetn)
      s_exc_hi |=> trap_ff
         || (mem_we_ff && mem_wdata_ff[15:8] == $past(status_low_byte, 2));
   endproperty
   a_exc_srl: assert property (p_exc_srl)
      else $error("exception push lost status byte");

   property p_sp_even;
      @(posedge core_clk) disable iff (!resetn)
      is_wrsp |=> sp_ff[0] == 1'b0 && sp_ff[15:1] == ($past(op_data) >> 1);
   endproperty
   a_sp_even: assert property (p_sp_even)
      else $error("pointer write not word aligned");

   property p_limit_even;
      @(posedge core_clk) disable iff (!resetn)
      wr_limit && wr_strb[0] |=> limit_ff[0] == 1'b0;
   endproperty
   a_limit_even: assert property (p_limit_even)
      else $error("limit bit zero set");

   property p_irq;
      @(posedge core_clk) disable iff (!resetn)
      |(status_ff & enable_ff) |=> irq_ff;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled event did not raise irq");
endmodule

// [bench/splc_core_model.sv]
// core-side requester for the stack op port
`timescale 1ns/1ns
module splc_core_model
   import splc_pkg::*;
(
   input wire logic core_clk,
   input wire logic op_ready,
   output logic op_valid,
   output splc_op_t op_kind,
   output logic [15:0] op_data,
   output logic [SPLC_PC_W-1:0] pc_in,
   output logic [7:0] status_low_byte
);
   initial begin
      op_valid = 1'b0;
      op_kind = SPLC_OP_EACHK;
      op_data = 16'h0000;
      pc_in = '0;
      status_low_byte = 8'h00;
   end

   // ---------------------------------------------------------------
   // one request, held until the edge that sees op_ready high
   // ---------------------------------------------------------------
   task automatic issue(input splc_op_t k, input logic [15:0] d,
      input logic [SPLC_PC_W-1:0] pc, input logic [7:0] sb,
      input int dly, output bit ok);
      int i;
      ok = 1'b0;
      repeat (dly + 1) @(posedge core_clk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_data <= d;
      pc_in <= pc;
      status_low_byte <= sb;
      for (i = 0; i < 100 && !ok; i++) begin
         @(negedge core_clk);
         ok = (op_ready === 1'b1);
      end
      @(posedge core_clk);
      op_valid <= 1'b0;
      // released lines flip so a stale value can never look right
      op_data <= ~d;
      pc_in <= ~pc;
      status_low_byte <= ~sb;
   endtask
endmodule

// [bench/splc_top_tb_top.sv]
// self-checking bench for the stack pointer limit trap unit
`timescale 1ns/1ns
module splc_top_tb_top
   import splc_pkg::*;
;
   logic core_clk, resetn;
   logic [SPLC_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic op_valid, op_ready, mem_we, mem_re, stack_trap, irq;
   splc_op_t op_kind, k_r;
   logic [15:0] op_data, stack_pointer_reg, mem_addr, mem_wdata, d_r;
   logic [SPLC_PC_W-1:0] pc_in;
   logic [7:0] status_low_byte;
   int num_errors, n_compared, seed, i, m_sp, m_lim, m_st;
   // addresses of words still on the stack, newest last
   int stk[$];
   splc_op_t ks [3] = '{SPLC_OP_PUSH, SPLC_OP_POP, SPLC_OP_EACHK};

   splc_top u_splc_top (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_kind,
      .op_data, .pc_in, .status_low_byte, .op_ready, .stack_pointer_reg,
      .mem_we, .mem_re, .mem_addr, .mem_wdata, .stack_trap, .irq);
   splc_core_model u_splc_core_model (.core_clk, .op_ready, .op_valid,
      .op_kind, .op_data, .pc_in, .status_low_byte);

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------
   // checking and bus helpers
   // ---------------------------------------------------------------
   task automatic finish_test();
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // readies are flops, so the negedge value is what the next edge sees
   task automatic wait_hi(input int w);
      int n;
      for (n = 0; n < 200; n++) begin
         @(negedge core_clk);
         if (w == 0 && s_axi_awready === 1'b1 && s_axi_wready === 1'b1)
            return;
         if (w == 1 && s_axi_bvalid === 1'b1)
            return;
         if (w == 2 && s_axi_arready === 1'b1)
            return;
         if (w == 3 && s_axi_rvalid === 1'b1)
            return;
      end
      num_errors++;
      finish_test();
   endtask

   task automatic axi_wr(input logic [SPLC_AW-1:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wait_hi(0);
      @(posedge core_clk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_awaddr <= ~a;
      s_axi_wdata <= ~d;
      wait_hi(1);
      chk(s_axi_bresp, er);
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [SPLC_AW-1:0] a, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wait_hi(2);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      wait_hi(3);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // reference stack model, compared at every op result
   // ---------------------------------------------------------------
   task automatic do_op(input splc_op_t k, input logic [15:0] d,
      input int dly);
      logic [SPLC_PC_W-1:0] pc;
      logic [7:0] sb;
      logic [15:0] wd;
      int ea, j, n;
      bit ok, tr, wr;
      pc = SPLC_PC_W'($random(seed));
      sb = 8'($random(seed));
      n = (k == SPLC_OP_CALL || k == SPLC_OP_EXC) ? 2 : 1;
      wr = (k == SPLC_OP_PUSH || n == 2);
      u_splc_core_model.issue(k, d, pc, sb, dly, ok);
      if (!ok) begin
         num_errors++;
         finish_test();
      end
      for (j = 0; j < n; j++) begin
         #1;
         ea = (k == SPLC_OP_POP) ? m_sp - 2 : m_sp;
         if (k == SPLC_OP_EACHK)
            ea = int'(d);
         tr = (k != SPLC_OP_WRSP) && (ea > m_lim || ea < 'h800);
         chk(stack_trap, tr);
         chk(mem_we, wr && !tr);
         chk(mem_re, k == SPLC_OP_POP && !tr);
         if (tr) begin
            m_st = m_st | int'(ea > m_lim) | 2 * int'(ea < 'h800);
            break;
         end
         wd = (k == SPLC_OP_PUSH) ? d : (j == 0) ? pc[15:0]
            : {(k == SPLC_OP_EXC) ? sb : 8'h00, 1'b0, pc[22:16]};
         if (k != SPLC_OP_EACHK && k != SPLC_OP_WRSP)
            chk(mem_addr, ea);
         if (wr) chk(mem_wdata, wd);
         if (k == SPLC_OP_POP && stk.size() > 0)
            chk(mem_addr, stk.pop_back());
         if (wr)
            stk.push_back(ea);
         if (k == SPLC_OP_WRSP) begin
            m_sp = d & 'hfffe;
            stk.delete();
         end else if (k != SPLC_OP_EACHK)
            m_sp = (k == SPLC_OP_POP) ? m_sp - 2 : m_sp + 2;
         if (j + 1 < n)
            @(posedge core_clk);
      end
      chk(stack_pointer_reg, m_sp);
   endtask

   task automatic set_lim(input logic [15:0] v);
      axi_wr(SPLC_OFF_LIMIT, {16'h0000, v}, SPLC_RESP_OKAY);
      m_lim = v & 'hfffe;
      // no pointer access straight after a limit write
      repeat (2) @(posedge core_clk);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 66;
      num_errors = 0;
      n_compared = 0;
      resetn = 1'b0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      m_sp = 'h800;
      m_st = 0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      chk(op_ready, 1'b1);
      chk(irq, 1'b0);
      rd_chk(SPLC_OFF_SP, 32'h0800, SPLC_RESP_OKAY);
      set_lim(16'h0805);
      rd_chk(SPLC_OFF_LIMIT, 32'h0804, SPLC_RESP_OKAY);
      axi_wr(8'h14, 32'h1, SPLC_RESP_SLVERR);
      rd_chk(8'h14, 32'h0, SPLC_RESP_SLVERR);
      // push at the limit itself passes, the next one traps
      for (i = 0; i < 4; i++) begin
         do_op(SPLC_OP_PUSH, 16'($random(seed)), i % 3);
      end
      for (i = 0; i < 4; i++) do_op(SPLC_OP_POP, 16'h0, 0);
      rd_chk(SPLC_OFF_STATUS, 32'h3, SPLC_RESP_OKAY);
      chk(irq, 1'b0);
      axi_wr(SPLC_OFF_ENABLE, 32'h2, SPLC_RESP_OKAY);
      repeat (2) @(posedge core_clk);
      #1;
      chk(irq, 1'b1);
      axi_wr(SPLC_OFF_CLEAR, 32'h2, SPLC_RESP_OKAY);
      repeat (2) @(posedge core_clk);
      #1;
      chk(irq, 1'b0);
      m_st = 1;
      rd_chk(SPLC_OFF_STATUS, 32'h1, SPLC_RESP_OKAY);
      rd_chk(SPLC_OFF_CLEAR, 32'h0, SPLC_RESP_OKAY);
      rd_chk(SPLC_OFF_ENABLE, 32'h2, SPLC_RESP_OKAY);
      set_lim(16'hfffe);
      do_op(SPLC_OP_CALL, 16'h0, 0);
      do_op(SPLC_OP_EXC, 16'h0, 1);
      do_op(SPLC_OP_WRSP, 16'h1235, 0);
      rd_chk(SPLC_OFF_SP, m_sp, SPLC_RESP_OKAY);
      set_lim(16'h0900);
      // pointer above the limit: frame aborted at its low word, nothing written
      do_op(SPLC_OP_CALL, 16'h0, 0);
      @(posedge core_clk);
      #1;
      chk(mem_we, 1'b0);
      do_op(SPLC_OP_WRSP, 16'h0800, 0);
      set_lim(16'h0810);
      for (i = 0; i < 30; i++) begin
         k_r = ks[$unsigned($random(seed)) % 3];
         d_r = 16'h07f8 + 16'($unsigned($random(seed)) % 32);
         do_op(k_r, d_r, i % 2);
      end
      rd_chk(SPLC_OFF_STATUS, m_st, SPLC_RESP_OKAY);
      finish_test();
   end
endmodule
